//--- inc/rgm_params.svh
// Constants for the RGMII MAC-side port: clock rates and half periods.
// Assumes the core clock runs at 50 MHz; times are held in picoseconds.
`ifndef RGM_PARAMS_SVH
`define RGM_PARAMS_SVH

// Core clock period
`define RGM_CLK_PERIOD_PS 32'h0000_4E20
// Half periods of the transmit clock per speed (125, 25 and 2.5 MHz)
`define RGM_TXC_HALF_1000_PS 32'h0000_0FA0
`define RGM_TXC_HALF_100_PS 32'h0000_4E20
`define RGM_TXC_HALF_10_PS 32'h0003_0D40
// Half period of the 25 MHz reference clock for the PHY
`define RGM_REF_HALF_PS 32'h0000_4E20
// Buffer shape in the transmit path
`define RGM_FIFO_DEPTH 8
`define RGM_FIFO_WIDTH 9
// Width of the half-period counters
`define RGM_CNT_W 8
// Idle value driven on the data pins
`define RGM_IDLE_NIBBLE 4'h0

`endif

//--- inc/rgm_pkg.sv
// Types shared by the RGMII MAC-side port and its transmit buffer.
// Assumes rgm_params.svh sits on the include path.
`include "rgm_params.svh"

package rgm_pkg;

  // Link speed selected by the MAC
  typedef enum logic [1:0] {
    RGM_SPD_10 = 2'b00,
    RGM_SPD_100 = 2'b01,
    RGM_SPD_1000 = 2'b10
  } rgm_speed_e;

  // One byte of a frame with its error mark
  typedef struct packed {
    logic err;
    logic [7:0] data;
  } rgm_byte_s;

  // Whole state of the port
  typedef struct packed {
    logic txc;
    logic tx_ctl;
    logic [3:0] txd;
    logic [3:0] tx_hi;
    logic tx_en;
    logic tx_err;
    logic [`RGM_CNT_W-1:0] tx_cnt;
    logic ref_clk;
    logic [`RGM_CNT_W-1:0] ref_cnt;
    logic rxc_s1;
    logic rxc_s2;
    logic rxc_prev;
    logic ctl_s1;
    logic ctl_s2;
    logic [3:0] rxd_s1;
    logic [3:0] rxd_s2;
    logic gig_s1;
    logic gig_s2;
    logic gig_prev;
    logic [3:0] rx_lo;
    logic rx_dv;
    rgm_byte_s rx_byte;
    logic rx_valid;
    logic rx_active;
  } rgm_port_state_s;

endpackage

//--- tb/rgm_mac_port_bench.sv
// Bench for the RGMII port: TX at each speed, then RX.
// Assumes the checker binds itself to the port.
`timescale 1ns/1ps
`default_nettype none

module rgm_mac_port_bench;
  import rgm_pkg::*;
  logic clk, srst, tx_valid, tx_ready, rx_valid, rx_active, tx_ctl, txc, rx_ctl, rxc, full;
  logic use_phy_gig_clock, phy_supplied_gig_clock, phy_ref_clock_out;
  logic [3:0] txd, rxd;
  rgm_speed_e speed_sel;
  rgm_byte_s tx_in, rx_out;
  logic [8:0] rx_got[$];
  int n_fail, n_compared, cyc;

  rgm_mac_port u_dut (
    .clk(clk),
    .srst(srst),
    .speed_sel(speed_sel),
    .use_phy_gig_clock(use_phy_gig_clock),
    .tx_in(tx_in),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready),
    .rx_out(rx_out),
    .rx_valid(rx_valid),
    .rx_active(rx_active),
    .txd(txd),
    .tx_ctl(tx_ctl),
    .txc(txc),
    .rxd(rxd),
    .rx_ctl(rx_ctl),
    .rxc(rxc),
    .phy_supplied_gig_clock(phy_supplied_gig_clock),
    .phy_ref_clock_out(phy_ref_clock_out)
  );
  rgm_phy_model u_phy (
    .rxd(rxd),
    .rx_ctl(rx_ctl),
    .rxc(rxc),
    .txd(txd),
    .tx_ctl(tx_ctl),
    .txc(txc)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // PHY gigabit clock, slowed so the core can sample it; edges avoid rising clk edges
  initial begin
    phy_supplied_gig_clock = 1'b0;
    forever #32 phy_supplied_gig_clock = ~phy_supplied_gig_clock;
  end

  // Gather RX bytes; the run needs well under 1000 cycles
  always @(posedge clk) begin
    cyc++;
    if (rx_valid === 1'b1) rx_got.push_back(rx_out);
    if (cyc == 3000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %h, not %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Twelve bytes back to back: 10M must refuse some, all arrive in order
  task automatic test_tx(input rgm_speed_e s, input logic gig);
    srst <= 1'b1;
    speed_sel <= s;
    use_phy_gig_clock <= gig;
    full = 1'b0;
    u_phy.got.delete();
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      tx_in <= {&i[1:0], 8'hA5 ^ i[7:0]};
      tx_valid <= 1'b1;
      @(posedge clk);
      while (tx_ready !== 1'b1) begin
        full = 1'b1;
        @(posedge clk);
      end
    end
    tx_valid <= 1'b0;
    for (int w = 0; w < 300 && u_phy.got.size() < 12; w++) @(posedge clk);
    if (s == RGM_SPD_10) chk(9'(full), 9'h001);
    for (int i = 0; i < 12; i++) chk(u_phy.got[i], {&i[1:0], 8'hA5 ^ i[7:0]});
    $display("tx test done, speed %0d, follow %0d", s, gig);
  endtask

  // Clean and errored bytes; one idle period gives nothing extra
  task automatic test_rx;
    logic [8:0] exp [4] = '{9'h0A5, 9'h13C, 9'h0FF, 9'h100};
    rx_got.delete();
    #5;
    foreach (exp[i]) u_phy.send(exp[i]);
    chk(9'(rx_active), 9'h001);
    u_phy.idle_period();
    for (int w = 0; w < 20 && rx_got.size() < 4; w++) @(posedge clk);
    foreach (exp[i]) chk(rx_got[i], exp[i]);
    chk(9'(rx_got.size()), 9'h004);
    chk(9'(rx_active), 9'h000);
    $display("rx test done");
  endtask

  // Each speed, then gigabit following the PHY clock, then receive
  initial begin
    tx_in <= '0;
    tx_valid <= 1'b0;
    test_tx(RGM_SPD_10, 1'b0);
    test_tx(RGM_SPD_100, 1'b0);
    test_tx(RGM_SPD_1000, 1'b0);
    test_tx(RGM_SPD_1000, 1'b1);
    test_rx();
    end_sim();
  end
endmodule // rgm_mac_port_bench
`default_nettype wire

//--- tb/rgm_mac_port_properties.sv
// Pin checker for the RGMII port.
// Assumes speed changes only under reset.
`timescale 1ns/1ps
`default_nettype none

module rgm_mac_port_properties (
  input wire logic clk, // Clock
  input wire logic srst, // Reset
  input wire rgm_pkg::rgm_speed_e speed_sel, // Speed
  input wire logic [3:0] txd, // TX data
  input wire logic tx_ctl, // TX control
  input wire logic txc, // TX clock
  input wire logic rx_ctl, // RX control
  input wire logic rxc, // RX clock
  input wire logic rx_valid, // Byte out
  input wire logic rx_active, // Valid level
  input wire logic phy_ref_clock_out // Ref clock
);
  import rgm_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Receive path lags three cycles: two sync flops and one register
  a_ref_runs: assert property (
    !$past(srst) |-> phy_ref_clock_out != $past(phy_ref_clock_out)) else $error("ref stalled");
  a_txc_fast: assert property (
    $rose(txc) && speed_sel == RGM_SPD_100 |=> $fell(txc)) else $error("txc 100M half");
  a_txc_slow: assert property (
    $rose(txc) && speed_sel == RGM_SPD_10 |-> ##10 $fell(txc)) else $error("txc 10M half");
  a_idle_zero: assert property (
    $rose(txc) && !tx_ctl |-> txd == 4'h0) else $error("idle data");
  a_ctl_fall: assert property (
    $fell(txc) && !$past(tx_ctl) |-> !tx_ctl) else $error("lone error");
  a_txd_edge: assert property (
    txd != $past(txd) |-> txc != $past(txc)) else $error("txd off txc");
  a_rx_level: assert property (
    $rose(rxc) |-> ##3 rx_active == $past(rx_ctl, 3)) else $error("rx level");
  a_rx_byte: assert property (
    $fell(rxc) && rx_active |-> ##3 rx_valid) else $error("rx byte");
endmodule // rgm_mac_port_properties

bind rgm_mac_port rgm_mac_port_properties u_props (
  .clk(clk),
  .srst(srst),
  .speed_sel(speed_sel),
  .txd(txd),
  .tx_ctl(tx_ctl),
  .txc(txc),
  .rx_ctl(rx_ctl),
  .rxc(rxc),
  .rx_valid(rx_valid),
  .rx_active(rx_active),
  .phy_ref_clock_out(phy_ref_clock_out)
);
`default_nettype wire

//--- tb/rgm_phy_model.sv
// PHY model: sends RX bytes, collects TX bytes.
// TX pins are edge-aligned, so they are read 2 ns late.
`timescale 1ns/1ps
`default_nettype none

module rgm_phy_model (
  output logic [3:0] rxd, // RX data
  output logic rx_ctl, // RX control
  output logic rxc, // RX clock
  input wire logic [3:0] txd, // TX data
  input wire logic tx_ctl, // TX control
  input wire logic txc // TX clock
);
  logic [4:0] lo;
  logic [8:0] got[$];
  initial {rxd, rx_ctl, rxc} = 6'h00;
  // Enable and low nibble, then byte with enable XOR control as error
  always @(posedge txc) #2 lo = {tx_ctl, txd};
  always @(negedge txc) #2 if (lo[4]) got.push_back({~tx_ctl, txd, lo[3:0]});
  // Data centred on rxc; bytes back to back, one rxc period each
  task automatic send(input logic [8:0] b);
    {rx_ctl, rxd} = {1'b1, b[3:0]};
    #40 rxc = 1'b1;
    #40 {rx_ctl, rxd} = {~b[8], b[7:4]};
    #40 rxc = 1'b0;
    #40;
  endtask
  // One rxc period with control low and data inverted: no byte
  task automatic idle_period;
    {rx_ctl, rxd} = {1'b0, ~rxd};
    #40 rxc = 1'b1;
    #80 rxc = 1'b0;
    #40;
  endtask
endmodule // rgm_phy_model
`default_nettype wire

//--- verilog/rgm_fifo.sv
// Small synchronous FIFO holding transmit bytes ahead of the pin logic.
// Assumes both sides run on clk; valid/ready handshake on each side.
`timescale 1ns/1ps
`default_nettype none

`include "rgm_params.svh"

module rgm_fifo #(
  parameter int WIDTH = `RGM_FIFO_WIDTH,
  parameter int DEPTH = `RGM_FIFO_DEPTH
) (
  input wire logic clk, // Core clock
  input wire logic srst, // Synchronous reset, high
  input wire logic [WIDTH-1:0] in_data, // Word to store
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  output logic [WIDTH-1:0] out_data, // Oldest word
  output logic out_valid, // Oldest word present
  input wire logic out_ready // Drain takes the word
);
  import rgm_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } rgm_fifo_state_s;

  rgm_fifo_state_s s_r;
  rgm_fifo_state_s s_nxt;
  logic push;
  logic pop;

  // Handshakes straight from the stored count
  assign in_ready = (s_r.count != CW'(DEPTH));
  assign out_valid = (s_r.count != '0);
  assign out_data = s_r.mem[s_r.rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer wrap assumes a power-of-two depth
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wr_ptr] = in_data;
      s_nxt.wr_ptr = s_r.wr_ptr + PW'(1);
    end
    if (pop) begin
      s_nxt.rd_ptr = s_r.rd_ptr + PW'(1);
    end
    s_nxt.count = s_r.count + CW'(push) - CW'(pop);
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule // rgm_fifo

`default_nettype wire

//--- verilog/rgm_mac_port.sv
// MAC-side RGMII port: transmit pins, receive pins, PHY reference clock.
// Assumes one 50 MHz core clock; receive pins arrive asynchronously.
// Transmit pins leave edge-aligned; the PHY or the board adds the skew.
// Division reaches 25 MHz at most; gigabit rate needs the PHY's clock.
// Receive pins must hold two core cycles around each rxc edge.
// Notes on behaviour
// - Drive transmit frame data on four pins
// - One control pin carries enable and error
// - Source transmit clock at speed-dependent rate
// - Decode valid and error from receive control
// - Output 25 MHz PHY reference clock, continuous except while srst is high
// - Optionally derive transmit clock from PHY clock
`timescale 1ns/1ps
`default_nettype none

`include "rgm_params.svh"

module rgm_mac_port (
  input wire logic clk, // Core clock, 50 MHz
  input wire logic srst, // Synchronous reset, high
  input wire rgm_pkg::rgm_speed_e speed_sel, // Link speed
  input wire logic use_phy_gig_clock, // Gigabit: follow PHY clock
  input wire rgm_pkg::rgm_byte_s tx_in, // Byte to send
  input wire logic tx_valid, // Byte offered
  output logic tx_ready, // Buffer has room
  output rgm_pkg::rgm_byte_s rx_out, // Received byte
  output logic rx_valid, // Received byte pulse
  output logic rx_active, // Receive data valid level
  output logic [3:0] txd, // Transmit data pins
  output logic tx_ctl, // Transmit control pin
  output logic txc, // Transmit clock pin
  input wire logic [3:0] rxd, // Receive data pins
  input wire logic rx_ctl, // Receive control pin
  input wire logic rxc, // Receive clock pin
  input wire logic phy_supplied_gig_clock, // 125 MHz from PHY
  output logic phy_ref_clock_out // 25 MHz reference to PHY
);
  import rgm_pkg::*;

  rgm_port_state_s s_r;
  rgm_port_state_s s_nxt;
  rgm_byte_s fifo_byte;
  logic fifo_valid;
  logic fifo_pop;
  logic tick;
  logic gig_mode;
  logic rx_rise;
  logic rx_fall;
  logic [3:0] lo_nib;
  logic [3:0] hi_nib;
  logic lo_ctl;
  logic hi_ctl;
  rgm_byte_s rx_join;

  // Cycles per half period, rounded down, never below one
  // Rounding down keeps txc at or above the asked rate, except at gigabit, where the floor of one gives 25 MHz
  function automatic logic [`RGM_CNT_W-1:0] half_cycles(input logic [31:0] half_ps);
    logic [31:0] c;
    c = half_ps / `RGM_CLK_PERIOD_PS;
    if (c == 32'h0000_0000) begin
      c = 32'h0000_0001;
    end
    return c[`RGM_CNT_W-1:0];
  endfunction

  // Half period per speed; the reserved code runs as 10M
  function automatic logic [`RGM_CNT_W-1:0] speed_half(input rgm_speed_e sp);
    logic [`RGM_CNT_W-1:0] h;
    case (sp)
      RGM_SPD_1000: h = half_cycles(`RGM_TXC_HALF_1000_PS);
      RGM_SPD_100: h = half_cycles(`RGM_TXC_HALF_100_PS);
      default: h = half_cycles(`RGM_TXC_HALF_10_PS);
    endcase
    return h;
  endfunction

  // Transmit buffer; its ready is the port's back-pressure
  // Eight bytes ride out the slow 10M drain against a burst
  rgm_fifo #(
    .WIDTH(`RGM_FIFO_WIDTH),
    .DEPTH(`RGM_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(clk),
    .srst(srst),
    .in_data(tx_in),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(fifo_byte),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // Edge detection only on second synchroniser stages
  assign gig_mode = (speed_sel == RGM_SPD_1000) && use_phy_gig_clock;
  assign rx_rise = s_r.rxc_s2 & ~s_r.rxc_prev;
  assign rx_fall = ~s_r.rxc_s2 & s_r.rxc_prev;
  // A byte leaves the buffer only as the clock rises
  assign fifo_pop = tick & ~s_r.txc & fifo_valid;

  // Divider tick, or an edge of the PHY's own gigabit clock
  always_comb begin
    if (gig_mode) begin
      tick = s_r.gig_s2 ^ s_r.gig_prev;
    end else begin
      tick = (s_r.tx_cnt >= speed_half(speed_sel) - `RGM_CNT_W'(1));
    end
  end

  // Pin values for the next txc edge; idle drives zero with control low
  always_comb begin
    if (fifo_valid) begin
      lo_nib = fifo_byte.data[3:0];
      hi_nib = fifo_byte.data[7:4];
      lo_ctl = 1'b1;
    end else begin
      lo_nib = `RGM_IDLE_NIBBLE;
      hi_nib = `RGM_IDLE_NIBBLE;
      lo_ctl = 1'b0;
    end
    hi_ctl = s_r.tx_en ^ s_r.tx_err;
  end

  // Byte as it stands at a falling rxc edge
  always_comb begin
    rx_join.data = {s_r.rxd_s2, s_r.rx_lo};
    rx_join.err = s_r.rx_dv ^ s_r.ctl_s2;
  end

  // Transmit pins straight from state, so they never glitch
  assign txd = s_r.txd;
  assign tx_ctl = s_r.tx_ctl;
  assign txc = s_r.txc;

  // Reference clock and receive side, also from state
  assign phy_ref_clock_out = s_r.ref_clk;
  assign rx_out = s_r.rx_byte;
  assign rx_valid = s_r.rx_valid;
  assign rx_active = s_r.rx_active;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rx_valid = 1'b0;
    // Two-stage synchronisers on every pin from the PHY
    // Receive clock; the third flop remembers the level for edges
    s_nxt.rxc_s1 = rxc;
    s_nxt.rxc_s2 = s_r.rxc_s1;
    s_nxt.rxc_prev = s_r.rxc_s2;
    // Control and data; they must hold two cycles around rxc edges
    s_nxt.ctl_s1 = rx_ctl;
    s_nxt.ctl_s2 = s_r.ctl_s1;
    s_nxt.rxd_s1 = rxd;
    s_nxt.rxd_s2 = s_r.rxd_s1;
    // PHY gigabit clock; read only in follow mode
    s_nxt.gig_s1 = phy_supplied_gig_clock;
    s_nxt.gig_s2 = s_r.gig_s1;
    s_nxt.gig_prev = s_r.gig_s2;

    // Reference clock: free-running divider, held low only while srst is high
    // Gating it would upset the PHY, which times itself from it
    if (s_r.ref_cnt >= half_cycles(`RGM_REF_HALF_PS) - `RGM_CNT_W'(1)) begin
      s_nxt.ref_cnt = '0;
      s_nxt.ref_clk = ~s_r.ref_clk;
    end else begin
      s_nxt.ref_cnt = s_r.ref_cnt + `RGM_CNT_W'(1);
    end

    // Transmit clock divider; held at zero while following the PHY clock
    // Cleared on each tick, so a new speed starts a fresh half period
    if (tick || gig_mode) begin
      s_nxt.tx_cnt = '0;
    end else begin
      s_nxt.tx_cnt = s_r.tx_cnt + `RGM_CNT_W'(1);
    end

    // Edge-aligned transmit; buffer underrun ends the frame
    // An empty buffer at a rise drops control, so the PHY sees the end
    if (tick) begin
      s_nxt.txc = ~s_r.txc;
      if (!s_r.txc) begin
        // Rising txc: low nibble, enable on control
        s_nxt.tx_en = fifo_valid;
        s_nxt.tx_err = fifo_valid & fifo_byte.err;
        s_nxt.txd = lo_nib;
        s_nxt.tx_hi = hi_nib;
        s_nxt.tx_ctl = lo_ctl;
      end else begin
        // Falling txc: high nibble, enable XOR error
        s_nxt.txd = s_r.tx_hi;
        s_nxt.tx_ctl = hi_ctl;
      end
    end

    // Receive: low nibble and valid on rising, high nibble on falling
    if (rx_rise) begin
      s_nxt.rx_lo = s_r.rxd_s2;
      s_nxt.rx_dv = s_r.ctl_s2;
      s_nxt.rx_active = s_r.ctl_s2;
    end
    // No back-pressure here: a byte not taken at once is lost
    if (rx_fall && s_r.rx_dv) begin
      s_nxt.rx_byte = rx_join;
      s_nxt.rx_valid = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule // rgm_mac_port

`default_nettype wire
